/* File: design/rmii_receive_and_mgmt_control.sv */
// Multi-port reduced-interface receive signalling with serial management and bus registers
//
// Behaviour
// R1: each port drives a 2-bit receive di-bit timed to the reference clock.
// R2: carrier_valid rises as soon as line carrier is seen, unaligned to reference.
// R3: carrier_valid falls on carrier loss, on a reference clock edge.
// R4: receive_error_flag is active high for an invalid code group, reference timed.
// R5: receive_error_flag is also high while the recovery loop is unlocked.
// R6: the station keeps the management clock at or below 8 MHz.
// R7: management reads and writes use one serial data line clocked by mdc.
// R8: with bit 18.1 set, status change pulls mgmt_interrupt_n low.
// R9: reading register 19 clears the pending management interrupt.
// R10: while mgmt_disable is high, serial management frames are ignored.
// R11: with mgmt_disable low, config pins only load defaults at reset.
// R12: after reset, serial management owns those bits; pins no longer override.
// R13: register bits are named register dot bit, registers 0-32, bits 0-15; the 5-bit register field in the code reaches 0-31 only.
// R14: the six-port variant lacks ports 6 and 7 and their outputs.
// R15: reference clock is 50 MHz; outputs move on its falling edge.
// R16: the MAC drives transmit enable and transmit di-bits on the reference clock.
// R17: management frames: preamble, start, opcode, address, register, turnaround, data.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rmii_rx_cfg.svh"
module rmii_receive_and_mgmt_control
  import rmii_rx_pkg::*;
#(
  parameter int NUM_PORTS = 8 // Six gives the smaller variant
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq,
  input wire logic reference_clock,
  input wire logic [2*NUM_PORTS-1:0] line_dibit,
  input wire logic [NUM_PORTS-1:0] line_carrier,
  input wire logic [NUM_PORTS-1:0] line_code_error,
  input wire logic [NUM_PORTS-1:0] line_locked,
  output logic [2*NUM_PORTS-1:0] receive_dibit,
  output logic [NUM_PORTS-1:0] carrier_valid,
  output logic [NUM_PORTS-1:0] receive_error_flag,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic mgmt_interrupt_n_out,
  output logic mgmt_interrupt_n_oe,
  input wire logic mgmt_disable,
  input wire logic [NUM_PORTS-1:0] cfg_mode_pin
);

  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
  localparam logic [3:0] MDC_MIN = 4'(`MDC_MIN_CYC);

  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mio_s1;
    logic mio_s2;
    logic dis_s1;
    logic dis_s2;
    logic [NUM_PORTS-1:0] cfg_s1;
    logic [NUM_PORTS-1:0] cfg_s2;
    logic [1:0] strap_cnt;
    mgmt_frame_type frame;
    logic [5:0] bit_cnt;
    logic [15:0] shreg;
    logic op_read;
    logic [4:0] reg_addr;
    logic [PW-1:0] port_sel;
    logic out_bit;
    logic out_en;
    logic [3:0] mdc_gap;
    logic [NUM_PORTS-1:0] int_en;
    logic [NUM_PORTS-1:0][1:0] int_stat;
    logic [NUM_PORTS-1:0] cfg_fx;
    logic pend;
    logic ack;
    logic [31:0] dat_o;
    logic [`EVT_WIDTH-1:0] status;
    logic [`EVT_WIDTH-1:0] mask;
    logic [4:0] phy_base;
  } ctrl_state_type;

  ctrl_state_type st;
  ctrl_state_type next_st;

  logic ref_fall;
  logic [NUM_PORTS-1:0] evt_car;
  logic [NUM_PORTS-1:0] evt_err;
  logic mdc_rise;
  logic [4:0] phy_off;
  logic rd_status_hit;

  // ----------------------------------------
  // Receive ports
  // ----------------------------------------
  // Reference clock must be slower than half of core_clk to be sampled here
  assign ref_fall = st.ref_s3 & ~st.ref_s2; // see R15

  // Only NUM_PORTS ports exist; the six-port build has no ports 6 and 7
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port // see R14
    rmii_port_rx u_port (
      .core_clk(core_clk),
      .rst(rst),
      .ref_fall(ref_fall),
      .line_dibit(line_dibit[2*p +: 2]),
      .line_carrier(line_carrier[p]),
      .line_code_error(line_code_error[p]),
      .line_locked(line_locked[p]),
      .receive_dibit(receive_dibit[2*p +: 2]), // see R1
      .carrier_valid(carrier_valid[p]),
      .receive_error_flag(receive_error_flag[p]),
      .carrier_event(evt_car[p]),
      .error_event(evt_err[p])
    );
  end

  // ----------------------------------------
  // Management frame and registers
  // ----------------------------------------
  assign mdc_rise = st.mdc_s2 & ~st.mdc_s3;
  assign phy_off = st.shreg[8:4] - st.phy_base;
  assign rd_status_hit = (st.frame == mf_header) && mdc_rise && (st.bit_cnt == 6'd11)
    && (st.shreg[10:9] == `OP_READ) && ({st.shreg[3:0], st.mio_s2} == `MREG_INT_STATUS)
    && (phy_off < 5'(NUM_PORTS)) && !st.dis_s2;

  // One process holds the frame walker, the register file and the bus slave
  always_comb begin
    logic [`EVT_WIDTH-1:0] evt;
    logic [15:0] rd_val;
    logic [PW-1:0] p_new;
    evt = '0;
    rd_val = '0;
    p_new = phy_off[PW-1:0];
    next_st = st;
    next_st.ref_s1 = reference_clock;
    next_st.ref_s2 = st.ref_s1;
    next_st.ref_s3 = st.ref_s2;
    next_st.mdc_s1 = mdc;
    next_st.mdc_s2 = st.mdc_s1;
    next_st.mdc_s3 = st.mdc_s2;
    next_st.mio_s1 = mdio_in;
    next_st.mio_s2 = st.mio_s1;
    next_st.dis_s1 = mgmt_disable;
    next_st.dis_s2 = st.dis_s1;
    next_st.cfg_s1 = cfg_mode_pin;
    next_st.cfg_s2 = st.cfg_s1;

    // Defaults are caught once the pin synchronisers have settled
    if (st.strap_cnt != 2'h3) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end
    if (st.strap_cnt == 2'h2) begin
      next_st.cfg_fx = st.cfg_s2; // see R11
    end else if (st.strap_cnt == 2'h3 && st.dis_s2) begin
      next_st.cfg_fx = st.cfg_s2; // No serial owner while disabled, so pins stay in charge
    end

    // Gap between clock edges; too short a gap means the station runs too fast
    if (mdc_rise) begin
      next_st.mdc_gap = 4'h1;
      if (st.mdc_gap < MDC_MIN && !st.dis_s2) begin
        evt[`EVT_MDC_FAST] = 1'b1; // see R6
      end
    end else if (st.mdc_gap != 4'hF) begin
      next_st.mdc_gap = st.mdc_gap + 4'h1;
    end

    // Serial frame, stepped on each rising management clock edge
    if (st.dis_s2) begin
      next_st.frame = mf_preamble; // see R10
      next_st.out_en = 1'b0;
      if (mdc_rise && !st.mio_s2 && st.bit_cnt == `PREAMBLE_ONES) begin
        evt[`EVT_MGMT_IGNORED] = 1'b1;
      end
      if (mdc_rise) begin
        next_st.bit_cnt = st.mio_s2 ? (st.bit_cnt == `PREAMBLE_ONES ? st.bit_cnt :
          st.bit_cnt + 6'd1) : 6'd0;
      end
    end else if (mdc_rise) begin // see R7
      case (st.frame)
        mf_preamble: begin
          if (st.mio_s2) begin
            next_st.bit_cnt = (st.bit_cnt == `PREAMBLE_ONES) ? st.bit_cnt : st.bit_cnt + 6'd1;
          end else begin
            next_st.frame = (st.bit_cnt == `PREAMBLE_ONES) ? mf_start : mf_preamble; // see R17
            next_st.bit_cnt = 6'd0;
          end
        end
        mf_start: begin
          next_st.frame = st.mio_s2 ? mf_header : mf_preamble;
          next_st.bit_cnt = 6'd0;
        end
        mf_header: begin
          next_st.shreg = {st.shreg[14:0], st.mio_s2};
          next_st.bit_cnt = st.bit_cnt + 6'd1;
          if (st.bit_cnt == 6'd11) begin
            next_st.bit_cnt = 6'd0;
            next_st.reg_addr = {st.shreg[3:0], st.mio_s2};
            next_st.port_sel = p_new;
            next_st.op_read = (st.shreg[10:9] == `OP_READ);
            next_st.frame = mf_preamble;
            // Addresses outside this device's block are left alone
            if (phy_off < 5'(NUM_PORTS) && (st.shreg[10:9] == `OP_READ ||
                st.shreg[10:9] == `OP_WRITE)) begin
              next_st.frame = mf_turnaround;
            end
            // Register number dot bit number picks the field; 32 is beyond the 5-bit field
            case ({st.shreg[3:0], st.mio_s2}) // see R13
              `MREG_MODE: rd_val[`MBIT_MODE_FX] = st.cfg_fx[p_new];
              `MREG_INT_ENABLE: rd_val[`MBIT_INT_ENABLE] = st.int_en[p_new];
              `MREG_INT_STATUS: rd_val[1:0] = st.int_stat[p_new];
              default: rd_val = '0;
            endcase
            next_st.shreg = rd_val;
          end
        end
        mf_turnaround: begin
          next_st.bit_cnt = st.bit_cnt + 6'd1;
          if (st.op_read && st.bit_cnt == 6'd0) begin
            next_st.out_en = 1'b1; // Second turnaround bit is driven low
            next_st.out_bit = 1'b0;
          end
          if (st.bit_cnt == 6'd1) begin
            next_st.frame = mf_data;
            next_st.bit_cnt = 6'd0;
            if (st.op_read) begin
              next_st.out_bit = st.shreg[15];
              next_st.shreg = {st.shreg[14:0], 1'b0};
            end
          end
        end
        mf_data: begin
          next_st.bit_cnt = st.bit_cnt + 6'd1;
          if (st.op_read) begin
            if (st.bit_cnt == 6'd15) begin
              next_st.out_en = 1'b0;
              next_st.frame = mf_preamble;
              next_st.bit_cnt = 6'd0;
              evt[`EVT_MGMT_READ] = 1'b1;
            end else begin
              next_st.out_bit = st.shreg[15];
              next_st.shreg = {st.shreg[14:0], 1'b0};
            end
          end else begin
            next_st.shreg = {st.shreg[14:0], st.mio_s2};
            if (st.bit_cnt == 6'd15) begin
              next_st.frame = mf_preamble;
              next_st.bit_cnt = 6'd0;
              evt[`EVT_MGMT_WRITE] = 1'b1;
              // Once defaults are caught and while mgmt_disable is low, only the serial side changes these bits
              if (st.reg_addr == `MREG_MODE && st.strap_cnt == 2'h3) begin
                next_st.cfg_fx[st.port_sel] = next_st.shreg[`MBIT_MODE_FX]; // see R12
              end
              if (st.reg_addr == `MREG_INT_ENABLE) begin
                next_st.int_en[st.port_sel] = next_st.shreg[`MBIT_INT_ENABLE];
              end
            end
          end
        end
        default: begin
          next_st.frame = mf_preamble;
          next_st.out_en = 1'b0;
        end
      endcase
    end

    // Reading the status register clears it, but a new event in that cycle stays
    if (rd_status_hit) begin
      next_st.int_stat[p_new] = 2'h0; // see R9
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_st.int_stat[i] = next_st.int_stat[i] | {evt_err[i], evt_car[i]};
    end
    next_st.pend = |(st.int_en & pend_vec(st));
    if (next_st.pend && !st.pend) begin
      evt[`EVT_MGMT_IRQ] = 1'b1;
    end

    // Bus slave: ack one cycle after the strobe, dropped the cycle after
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      case (wb_adr_i)
        `OFS_EVT_STATUS: next_st.dat_o = 32'(st.status);
        `OFS_EVT_MASK: next_st.dat_o = 32'(st.mask);
        `OFS_CONTROL: next_st.dat_o = 32'(st.phy_base);
        `OFS_PORT_STATE: next_st.dat_o = 32'({receive_error_flag, carrier_valid});
        `OFS_MGMT_STATE: next_st.dat_o = 32'({st.int_en, st.cfg_fx});
        default: next_st.dat_o = 32'h00000000;
      endcase
    end
    // Write lands on the edge where the master sees ack
    if (wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0]) begin
      case (wb_adr_i)
        `OFS_EVT_STATUS: next_st.status = st.status & ~wb_dat_i[`EVT_WIDTH-1:0];
        `OFS_EVT_MASK: next_st.mask = wb_dat_i[`EVT_WIDTH-1:0];
        `OFS_CONTROL: next_st.phy_base = wb_dat_i[4:0];
        default: next_st.status = next_st.status;
      endcase
    end
    next_st.status = next_st.status | evt;
  end

  // Per-port pending view: any status bit of a port counts
  function automatic logic [NUM_PORTS-1:0] pend_vec(input ctrl_state_type s);
    logic [NUM_PORTS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      v[i] = |s.int_stat[i];
    end
    return v;
  endfunction : pend_vec

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.frame <= mf_preamble;
      st.mask <= `RST_EVT_MASK;
      st.phy_base <= `RST_PHY_BASE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mdio_out = st.out_bit;
  assign mdio_oe = st.out_en;
  assign mgmt_interrupt_n_out = 1'b0; // Open drain: only ever pulls low
  assign mgmt_interrupt_n_oe = st.pend; // see R8
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat_o;
  assign irq = |(st.status & st.mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [4:0] oe_rises;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_rises <= 5'h00;
    end else begin
      oe_rises <= !mdio_oe ? 5'h00 : (mdc_rise ? oe_rises + 5'h01 : oe_rises);
    end
  end

  chk_ack_single_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held for more than one cycle");

  chk_ack_next_cycle: assert property (@(posedge core_clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");

  chk_disable_quiet: assert property (@(posedge core_clk) disable iff (rst) // see R10
    st.dis_s2 |=> !mdio_oe) else $error("data line driven while management disabled");

  chk_status_read_clear: assert property (@(posedge core_clk) disable iff (rst) // see R9
    rd_status_hit && evt_car == '0 && evt_err == '0 |=> st.int_stat[st.port_sel] == 2'h0)
    else $error("status not cleared by read");

  chk_irq_needs_enable: assert property (@(posedge core_clk) disable iff (rst) // see R8
    mgmt_interrupt_n_oe |-> (st.int_en != '0)) else $error("interrupt pin without enable");

  chk_ta_low: assert property (@(posedge core_clk) disable iff (rst) // see R17
    $rose(mdio_oe) |-> !mdio_out) else $error("turnaround bit not driven low");

  chk_read_length: assert property (@(posedge core_clk) disable iff (rst) // see R17
    $fell(mdio_oe) && !$past(st.dis_s2) |-> oe_rises == 5'h11)
    else $error("read frame not seventeen clock edges long");

  chk_strap_load: assert property (@(posedge core_clk) disable iff (rst) // see R11
    st.strap_cnt == 2'h2 |=> st.cfg_fx == $past(st.cfg_s2)) else $error("defaults not loaded");

endmodule : rmii_receive_and_mgmt_control

/* File: design/rmii_rx_cfg.svh */
// Offsets, field positions, reset values and timing counts of the receive and management block
`ifndef RMII_RX_CFG_SVH
`define RMII_RX_CFG_SVH

// ----------------------------------------
// Bus register offsets (byte addresses)
// ----------------------------------------
`define OFS_EVT_STATUS 8'h00
`define OFS_EVT_MASK 8'h04
`define OFS_CONTROL 8'h08
`define OFS_PORT_STATE 8'h0C
`define OFS_MGMT_STATE 8'h10

// ----------------------------------------
// Event bits of status and mask
// ----------------------------------------
`define EVT_WIDTH 5
`define EVT_MGMT_WRITE 0
`define EVT_MGMT_READ 1
`define EVT_MGMT_IGNORED 2
`define EVT_MDC_FAST 3
`define EVT_MGMT_IRQ 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_EVT_MASK 5'h00
`define RST_PHY_BASE 5'h00

// ----------------------------------------
// Management register map
// ----------------------------------------
`define MREG_MODE 5'h10
`define MREG_INT_ENABLE 5'h12
`define MREG_INT_STATUS 5'h13
`define MBIT_MODE_FX 0
`define MBIT_INT_ENABLE 1
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define PREAMBLE_ONES 6'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_CLK_KHZ 40000
`define REF_CLK_KHZ 50000
`define MDC_MAX_KHZ 8000
`define MDC_MIN_CYC ((`CORE_CLK_KHZ + `MDC_MAX_KHZ - 1) / `MDC_MAX_KHZ)

`endif

/* File: design/rmii_rx_pkg.sv */
// Types shared by the receive and management block
package rmii_rx_pkg;

  // Progress through one serial management frame
  typedef enum logic [2:0] {
    mf_preamble,
    mf_start,
    mf_header,
    mf_turnaround,
    mf_data
  } mgmt_frame_type;

endpackage : rmii_rx_pkg

/* File: design/rmii_port_rx.sv */
// One port of reduced-interface receive signalling
`timescale 1ns/1ps
module rmii_port_rx (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ref_fall,
  input wire logic [1:0] line_dibit,
  input wire logic line_carrier,
  input wire logic line_code_error,
  input wire logic line_locked,
  output logic [1:0] receive_dibit,
  output logic carrier_valid,
  output logic receive_error_flag,
  output logic carrier_event,
  output logic error_event
);

  typedef struct packed {
    logic [1:0] dat_s1;
    logic [1:0] dat_s2;
    logic car_s1;
    logic car_s2;
    logic err_s1;
    logic err_s2;
    logic lock_s1;
    logic lock_s2;
    logic [1:0] dibit;
    logic valid;
    logic error;
  } port_state_type;

  port_state_type st;
  port_state_type next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Line signals are asynchronous, so everything passes two flops first
  always_comb begin
    next_st = st;
    next_st.dat_s1 = line_dibit;
    next_st.dat_s2 = st.dat_s1;
    next_st.car_s1 = line_carrier;
    next_st.car_s2 = st.car_s1;
    next_st.err_s1 = line_code_error;
    next_st.err_s2 = st.err_s1;
    next_st.lock_s1 = line_locked;
    next_st.lock_s2 = st.lock_s1;
    // Carrier raises the valid flag at once, without waiting for a reference edge
    if (st.car_s2) begin
      next_st.valid = 1'b1; // see R2
    end
    // Data, error and the carrier drop all move on the falling reference edge
    if (ref_fall) begin
      next_st.dibit = st.car_s2 ? st.dat_s2 : 2'h0; // see R1 see R15
      next_st.error = (st.err_s2 & st.car_s2) | ~st.lock_s2; // see R4 see R5
      if (!st.car_s2) begin
        next_st.valid = 1'b0; // see R3
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign receive_dibit = st.dibit;
  assign carrier_valid = st.valid;
  assign receive_error_flag = st.error;
  assign carrier_event = st.valid ^ next_st.valid;
  assign error_event = ~st.error & next_st.error;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_carrier_drop_sync: assert property (@(posedge core_clk) disable iff (rst) // see R3
    $fell(carrier_valid) |-> $past(ref_fall)) else $error("carrier dropped off the ref edge");

  chk_unlock_error: assert property (@(posedge core_clk) disable iff (rst) // see R5
    ref_fall && !st.lock_s2 |=> receive_error_flag) else $error("no error flag while unlocked");

endmodule : rmii_port_rx

/* File: tb/mgmt_station.sv */
// Management station model for the serial management clock and data line
`timescale 1ns/1ps
module mgmt_station (
  input wire logic core_clk,
  input wire logic mdio,
  output logic mdc,
  output logic st_out,
  output logic st_oe
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  // Clock stands low between frames and the line is released to its pull-up
  initial begin
    mdc = 1'h0;
    st_out = 1'h1;
    st_oe = 1'h0;
  end
  // Five core cycles a half period keeps mdc at 4 MHz
  task automatic half;
    repeat (5) @(posedge core_clk);
  endtask : half
  // One whole frame, MSB first; read data is taken just before the mdc rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    rd = 16'h0000;
    st_oe <= 1'h1;
    for (int i = 63; i >= 0; i--) begin
      // A read hands the line over at turnaround
      if (op == 2'h2 && i == 17) st_oe <= 1'h0;
      st_out <= fr[i];
      mdc <= 1'h0;
      half();
      if (i < 16) rd[i] = mdio;
      mdc <= 1'h1;
      half();
    end
    st_oe <= 1'h0;
    mdc <= 1'h0;
    // Idle gap so a following frame never reassigns in the same time step
    half();
  endtask : frame
endmodule : mgmt_station

/* File: tb/test_rmii_receive_and_mgmt_control.sv */
// Self-checking bench for the receive signalling and management block
`timescale 1ns/1ps
`include "rmii_rx_cfg.svh"
module test_rmii_receive_and_mgmt_control;
  localparam int N = 8;
  logic core_clk = 1'h0, rst = 1'h1, reference_clock = 1'h0, mgmt_disable = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_ack_o, irq;
  logic [2*N-1:0] line_dibit = '0, receive_dibit;
  logic [N-1:0] line_carrier = '0, line_code_error = '0, line_locked = '0, cfg_mode_pin = '0;
  logic [N-1:0] carrier_valid, receive_error_flag, cfg, ev;
  logic mdc, mdio_out, mdio_oe, st_out, st_oe, int_out, int_oe;
  logic [15:0] rd;
  logic [4:0] phy;
  int n_mismatch = 0, n_checks = 0, cycles = 0, pp;
  // Both open-drain lines carry pull-ups
  wire mdio_in = mdio_oe ? mdio_out : (st_oe ? st_out : 1'h1);
  wire int_pin = int_oe ? int_out : 1'h1;

  rmii_receive_and_mgmt_control #(.NUM_PORTS(N)) u_rmii_receive_and_mgmt_control (
    .core_clk(core_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq), .reference_clock(reference_clock),
    .line_dibit(line_dibit), .line_carrier(line_carrier), .line_code_error(line_code_error),
    .line_locked(line_locked), .receive_dibit(receive_dibit), .carrier_valid(carrier_valid),
    .receive_error_flag(receive_error_flag), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mgmt_interrupt_n_out(int_out),
    .mgmt_interrupt_n_oe(int_oe), .mgmt_disable(mgmt_disable), .cfg_mode_pin(cfg_mode_pin));
  mgmt_station u_mgmt_station (.core_clk(core_clk), .mdio(mdio_in), .mdc(mdc),
    .st_out(st_out), .st_oe(st_oe));

  // ----------------------------------------
  // Clocks, timeout and helpers
  // ----------------------------------------
  initial forever #12.5 core_clk = ~core_clk;
  // Reference clock at 200 ns; the odd start keeps it out of phase with the core
  initial begin
    #37;
    forever #100 reference_clock = ~reference_clock;
  end
  // Whole run needs about 4300 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic single cycle; ack and read data are both taken at the rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    // No fixed latency assumed; only the run timeout ends the wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'h0, 32'h0);
    chk(nm, e, q);
  endtask : rdchk
  // Expected {error, di-bit} of one port from the line levels
  function automatic logic [2:0] rx_exp(input int p);
    logic c;
    c = line_carrier[p];
    return {(line_code_error[p] & c) | ~line_locked[p], c ? line_dibit[2*p +: 2] : 2'h0};
  endfunction : rx_exp

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pp = $urandom(38);
    cfg = N'($urandom);
    cfg_mode_pin = cfg;
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rdchk("status", `OFS_EVT_STATUS, 32'h0);
    rdchk("mask", `OFS_EVT_MASK, 32'h0);
    rdchk("control", `OFS_CONTROL, 32'h0);
    rdchk("unmapped", 8'h1C, 32'h0);
    rdchk("cfg", `OFS_MGMT_STATE, {24'h0, cfg});
    cfg_mode_pin <= ~cfg;
    repeat (10) @(posedge core_clk);
    rdchk("cfg held", `OFS_MGMT_STATE, {24'h0, cfg});
    $display("reset test done");
    // Random line levels, checked after a few reference periods
    for (int t = 0; t < 8; t++) begin
      line_dibit <= 16'($urandom);
      line_carrier <= N'($urandom);
      line_code_error <= N'($urandom);
      line_locked <= N'($urandom | $urandom);
      repeat (24) @(posedge core_clk);
      @(negedge core_clk);
      for (int p = 0; p < N; p++) begin
        ev[p] = 1'(rx_exp(p) >> 2);
        chk("rx", rx_exp(p), {receive_error_flag[p], receive_dibit[2*p +: 2]});
        chk("carrier", line_carrier[p], carrier_valid[p]);
      end
      rdchk("port state", `OFS_PORT_STATE, {16'h0, ev, line_carrier});
    end
    $display("receive test done");
    // Carrier goes up well before the next reference falling edge
    line_locked <= '1;
    line_code_error <= '0;
    line_carrier <= '0;
    repeat (24) @(posedge core_clk);
    @(negedge reference_clock);
    repeat (4) @(posedge core_clk);
    line_carrier <= '1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("carrier rise", {N{1'h1}}, carrier_valid);
    $display("carrier test done");
    // Management write and read back on a random port
    pp = $urandom % N;
    phy = 5'($urandom % 24);
    wb(`OFS_CONTROL, 1'h1, {27'h0, phy});
    u_mgmt_station.frame(`OP_READ, phy + 5'(pp), `MREG_INT_STATUS, 16'h0, rd);
    u_mgmt_station.frame(`OP_WRITE, phy + 5'(pp), `MREG_INT_ENABLE, 16'h0002, rd);
    u_mgmt_station.frame(`OP_READ, phy + 5'(pp), `MREG_INT_ENABLE, 16'h0, rd);
    chk("int enable", 16'h0002, rd);
    rdchk("events", `OFS_EVT_STATUS, 32'h3);
    wb(`OFS_EVT_STATUS, 1'h1, 32'h1F);
    rdchk("events cleared", `OFS_EVT_STATUS, 32'h0);
    @(negedge core_clk);
    chk("int pin idle", 1'h1, int_pin);
    $display("management test done");
    // A carrier change raises both interrupts; reading register 19 clears the pin
    wb(`OFS_EVT_MASK, 1'h1, 32'h10);
    line_carrier[pp] <= 1'h0;
    repeat (30) @(posedge core_clk);
    @(negedge core_clk);
    chk("int pin", 1'h0, int_pin);
    chk("irq", 1'h1, irq);
    wb(`OFS_EVT_MASK, 1'h1, 32'h0);
    @(negedge core_clk);
    chk("irq masked", 1'h0, irq);
    wb(`OFS_EVT_MASK, 1'h1, 32'h10);
    u_mgmt_station.frame(`OP_READ, phy + 5'(pp), `MREG_INT_STATUS, 16'h0, rd);
    chk("int status", 16'h0001, rd);
    @(negedge core_clk);
    chk("int pin cleared", 1'h1, int_pin);
    wb(`OFS_EVT_STATUS, 1'h1, 32'h1F);
    @(negedge core_clk);
    chk("irq cleared", 1'h0, irq);
    $display("interrupt test done");
    // Frames are ignored while management is disabled
    mgmt_disable <= 1'h1;
    repeat (5) @(posedge core_clk);
    u_mgmt_station.frame(`OP_WRITE, phy + 5'(pp), `MREG_INT_ENABLE, 16'h0, rd);
    mgmt_disable <= 1'h0;
    repeat (5) @(posedge core_clk);
    rdchk("ignored", `OFS_EVT_STATUS, 32'h4);
    u_mgmt_station.frame(`OP_READ, phy + 5'(pp), `MREG_INT_ENABLE, 16'h0, rd);
    chk("enable kept", 16'h0002, rd);
    $display("disable test done");
    tally_and_finish();
  end
endmodule : test_rmii_receive_and_mgmt_control
